/* logic/emr_read_cycle.sv */
// External memory read cycle sequencer with per-space wait states
// How it works
// - Address goes onto the 14-bit bus with the space select, same cycle.
// - Program and data address and data paths share one external bus.
// - Exactly one of four active-low space selects is low per access.
// - Read strobe falls a quarter processor period after address and select.
// - Data seen while the strobe is low is captured one clock after it rises.
// - Strobe low lasts half a period plus one period per wait state.
// - Each of the four spaces has its own 0 to 15 wait count.
// - Every wait state adds exactly one processor period to the access.
// - Address, select and strobe stay stable during the wait states.
`timescale 1ns/1ps
`default_nettype none
module emr_read_cycle
  import emr_pkg::*;
#(
  parameter int DATA_WIDTH = 24
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // Read requests from the core
  input  wire logic                  start_read,
  input  wire logic [1:0]            read_space,
  input  wire logic                  use_program_bus,
  input  wire logic [ADDR_WIDTH-1:0] program_address,
  input  wire logic [ADDR_WIDTH-1:0] data_address,
  // Wait-state counts per space
  input  wire logic [WAIT_WIDTH-1:0] boot_wait,
  input  wire logic [WAIT_WIDTH-1:0] program_wait,
  input  wire logic [WAIT_WIDTH-1:0] data_wait,
  input  wire logic [WAIT_WIDTH-1:0] io_wait,
  // Results to the core
  output logic                       busy,
  output logic                       read_done,
  output logic                       read_to_program,
  output logic [DATA_WIDTH-1:0]      read_data,
  output logic                       sample_request,
  // External pins
  input  wire logic                  conversion_irq_n,
  input  wire logic [DATA_WIDTH-1:0] external_data,
  output logic [ADDR_WIDTH-1:0]      external_address,
  output logic                       boot_space_select_n,
  output logic                       data_space_select_n,
  output logic                       program_space_select_n,
  output logic                       io_space_select_n,
  output logic                       read_strobe_n
);
  if (DATA_WIDTH < 1 || DATA_WIDTH > 32) begin : g_width_check
    $error("DATA_WIDTH must be 1 to 32");
  end
  if (QUARTER_CYCLES > 255) begin : g_quarter_check
    $error("quarter period too long for the divider");
  end

  typedef struct packed {
    emr_state_type         fsm;
    logic                  busy;
    logic [DIV_WIDTH-1:0]  div;
    logic                  half_done;
    logic                  base_step;
    logic [ADDR_WIDTH-1:0] addr;
    logic [3:0]            sel;
    logic                  strobe_n;
    logic [WAIT_WIDTH-1:0] waits;
    logic                  to_program;
    logic [DATA_WIDTH-1:0] data;
    logic                  done;
    logic [1:0]            irq_sync;
    logic                  irq_prev;
    logic                  sreq;
    logic [DATA_WIDTH-1:0] dsync0;
    logic [DATA_WIDTH-1:0] dsync1;
  } emr_core_type;

  emr_core_type          s;
  emr_core_type          next_s;
  logic                  tick;
  logic [WAIT_WIDTH-1:0] space_wait;
  logic [3:0]            space_onehot_n;
  logic                  accept;

  emr_wait_if wait_bus ();

  emr_wait_counter u_wait (
    .clock     (clock),
    .reset     (reset),
    .wait_port (wait_bus)
  );

  assign tick   = (s.div == DIV_WIDTH'(QUARTER_CYCLES - 1));
  assign accept = (s.fsm == EMR_IDLE) && start_read;

  always_comb begin
    case (read_space)
      SPACE_BOOT:    space_wait = boot_wait;
      SPACE_DATA:    space_wait = data_wait;
      SPACE_PROGRAM: space_wait = program_wait;
      SPACE_IO:      space_wait = io_wait;
      default:       space_wait = WAIT_RESET;
    endcase
    space_onehot_n = ~(4'h1 << read_space);
  end

  assign wait_bus.load  = accept;
  assign wait_bus.value = space_wait;
  assign wait_bus.tick  = tick;
  assign wait_bus.run   = (s.fsm == EMR_STROBE) && s.half_done;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    next_s.sreq = 1'b0;
    // Conversion-complete request, two stages then edge detect
    next_s.irq_sync = {s.irq_sync[0], conversion_irq_n};
    next_s.irq_prev = s.irq_sync[1];
    if (s.irq_prev && !s.irq_sync[1]) begin
      next_s.sreq = 1'b1;
    end
    next_s.dsync0 = external_data;
    next_s.dsync1 = s.dsync0;
    next_s.div    = tick ? '0 : s.div + 8'h01;
    case (s.fsm)
      EMR_IDLE: begin
        if (start_read) begin
          next_s.fsm        = EMR_SETUP;
          next_s.div        = '0;
          next_s.addr       = use_program_bus ? program_address : data_address;
          next_s.to_program = use_program_bus;
          next_s.sel        = space_onehot_n;
          next_s.waits      = space_wait;
          next_s.half_done  = 1'b0;
          next_s.base_step  = 1'b0;
        end
      end
      EMR_SETUP: begin
        if (tick) begin
          next_s.fsm      = EMR_STROBE;
          next_s.strobe_n = 1'b0;
        end
      end
      EMR_STROBE: begin
        // Address and select hold here; only the strobe changes, on the release below
        if (tick) begin
          if (!s.half_done) begin
            if (s.base_step) begin
              if (wait_bus.zero) begin
                next_s.fsm = EMR_HOLD;
              end else begin
                next_s.half_done = 1'b1;
              end
            end else begin
              next_s.base_step = 1'b1;
            end
          end else if (wait_bus.last) begin
            next_s.fsm = EMR_HOLD;
          end
          if (next_s.fsm == EMR_HOLD) begin
            next_s.strobe_n = 1'b1;
          end
        end
      end
      EMR_HOLD: begin
        // Synchronised data trails the pin by two clocks, so the word
        // seen while the strobe was low is taken one clock after the rise
        if (s.div == '0) begin
          next_s.data = s.dsync1;
          next_s.done = 1'b1;
        end
        // Select released a quarter period after the strobe rises
        if (tick) begin
          next_s.fsm = EMR_IDLE;
          next_s.sel = SELECT_IDLE;
        end
      end
      default: begin
        next_s.fsm      = EMR_IDLE;
        next_s.sel      = SELECT_IDLE;
        next_s.strobe_n = 1'b1;
      end
    endcase
    next_s.busy = (next_s.fsm != EMR_IDLE);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s <= '{fsm: EMR_IDLE, busy: 1'b0, div: '0, half_done: 1'b0, base_step: 1'b0,
             addr: ADDR_RESET, sel: SELECT_IDLE, strobe_n: 1'b1, waits: WAIT_RESET,
             to_program: 1'b0, data: '0, done: 1'b0, irq_sync: 2'h3, irq_prev: 1'b1,
             sreq: 1'b0, dsync0: '0, dsync1: '0};
    end else begin
      s <= next_s;
    end
  end

  assign busy                   = s.busy;
  assign read_done              = s.done;
  assign read_to_program        = s.to_program;
  assign read_data              = s.data;
  assign sample_request         = s.sreq;
  assign external_address       = s.addr;
  assign boot_space_select_n    = s.sel[SPACE_BOOT];
  assign data_space_select_n    = s.sel[SPACE_DATA];
  assign program_space_select_n = s.sel[SPACE_PROGRAM];
  assign io_space_select_n      = s.sel[SPACE_IO];
  assign read_strobe_n          = s.strobe_n;

  // Checking helpers
  logic [LOW_COUNT_WIDTH-1:0] low_count;
  logic [LOW_COUNT_WIDTH-1:0] setup_count;
  logic [LOW_COUNT_WIDTH-1:0] expected_low;
  logic [ADDR_WIDTH-1:0]      chosen_address;

  always_ff @(posedge clock) begin
    if (reset) begin
      low_count   <= '0;
      setup_count <= '0;
    end else begin
      low_count   <= read_strobe_n ? '0 : low_count + 16'h0001;
      setup_count <= (s.fsm == EMR_SETUP) ? setup_count + 16'h0001 : '0;
    end
  end

  assign chosen_address = use_program_bus ? program_address : data_address;
  assign expected_low = LOW_COUNT_WIDTH'(QUARTER_CYCLES
    * (HALF_QUARTERS + QUARTERS_PER_PERIOD * int'(s.waits)));

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  one_select_a: assert property (busy |-> $onehot(~s.sel))
    else $error("not exactly one space select low");
  idle_quiet_a: assert property (!busy |-> s.sel == SELECT_IDLE && read_strobe_n)
    else $error("select or strobe active while idle");
  addr_mux_a: assert property (accept |=> external_address
    == $past(chosen_address) && s.sel != SELECT_IDLE)
    else $error("address or select not placed with the request");
  strobe_setup_a: assert property ($fell(read_strobe_n) |->
    $past(s.sel) != SELECT_IDLE && $past(setup_count) == QUARTER_CYCLES - 1)
    else $error("strobe fell without a quarter period of setup");
  wait_stable_a: assert property (!read_strobe_n && $past(!read_strobe_n) |->
    $stable(external_address) && $stable(s.sel))
    else $error("address or select moved during the strobe");
  strobe_width_a: assert property ($rose(read_strobe_n) |-> low_count == expected_low)
    else $error("strobe low time differs from the wait-state length");
  capture_rise_a: assert property ($rose(read_strobe_n) |=>
    read_done && read_data == $past(s.dsync1))
    else $error("data not captured on the strobe rise");
  access_bound_a: assert property (accept |-> ##[1:300] read_done)
    else $error("access did not end");

  zero_wait_c: cover property (accept && space_wait == WAIT_RESET ##[1:20] read_done);
  full_wait_c: cover property (accept && space_wait == 4'hF ##[1:300] read_done);
  irq_read_c: cover property (sample_request ##[0:20] accept);
endmodule
`default_nettype wire

/* logic/emr_pkg.sv */
// Constants and types shared by the external memory read cycle design
package emr_pkg;
  localparam int CLOCK_PERIOD_NS     = 10;
  localparam int PROC_PERIOD_NS      = 40;
  localparam int QUARTER_NS          = PROC_PERIOD_NS / 4;
  localparam int QUARTER_CYCLES_RAW  = (QUARTER_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int QUARTER_CYCLES      = (QUARTER_CYCLES_RAW < 1) ? 1 : QUARTER_CYCLES_RAW;
  localparam int QUARTERS_PER_PERIOD = 4;
  localparam int HALF_QUARTERS       = 2;
  localparam int ADDR_WIDTH          = 14;
  localparam int WAIT_WIDTH          = 4;
  localparam int DIV_WIDTH           = 8;
  localparam int LOW_COUNT_WIDTH     = 16;

  localparam logic [1:0] SPACE_BOOT    = 2'h0;
  localparam logic [1:0] SPACE_DATA    = 2'h1;
  localparam logic [1:0] SPACE_PROGRAM = 2'h2;
  localparam logic [1:0] SPACE_IO      = 2'h3;

  localparam logic [3:0]            SELECT_IDLE  = 4'hF;
  localparam logic [ADDR_WIDTH-1:0] ADDR_RESET   = 14'h0000;
  localparam logic [WAIT_WIDTH-1:0] WAIT_RESET   = 4'h0;
  localparam logic [1:0]            PHASE_LAST   = 2'h3;

  typedef enum logic [1:0] {
    EMR_IDLE,
    EMR_SETUP,
    EMR_STROBE,
    EMR_HOLD
  } emr_state_type;
endpackage

/* logic/emr_wait_if.sv */
// Carrier between the read sequencer and its wait-state counter
`timescale 1ns/1ps
`default_nettype none
interface emr_wait_if;
  import emr_pkg::*;
  logic                  load;
  logic [WAIT_WIDTH-1:0] value;
  logic                  tick;
  logic                  run;
  logic                  zero;
  logic                  last;

  modport sequencer (output load, value, tick, run, input zero, last);
  modport counter (input load, value, tick, run, output zero, last);
endinterface
`default_nettype wire

/* logic/emr_wait_counter.sv */
// Wait-state down-counter, one step per processor clock period
`timescale 1ns/1ps
`default_nettype none
module emr_wait_counter
  import emr_pkg::*;
(
  // Clock and reset
  input wire logic         clock,
  input wire logic         reset,
  // Sequencer side
  emr_wait_if.counter      wait_port
);
  typedef struct packed {
    logic [WAIT_WIDTH-1:0] count;
    logic [1:0]            phase;
  } emr_count_type;

  emr_count_type s;
  emr_count_type next_s;

  always_comb begin
    next_s = s;
    if (wait_port.load) begin
      next_s.count = wait_port.value;
      next_s.phase = 2'h0;
    end else if (wait_port.run && wait_port.tick && s.count != WAIT_RESET) begin
      next_s.phase = s.phase + 2'h1;
      if (s.phase == PHASE_LAST) begin
        next_s.count = s.count - 4'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s <= '{count: WAIT_RESET, phase: 2'h0};
    end else begin
      s <= next_s;
    end
  end

  assign wait_port.zero = (s.count == WAIT_RESET);
  assign wait_port.last = (s.count == 4'h1) && (s.phase == PHASE_LAST);

  load_value_a: assert property (@(posedge clock) disable iff (reset)
    wait_port.load |=> s.count == $past(wait_port.value) && s.phase == 2'h0)
    else $error("wait counter did not load the space count");

  step_period_a: assert property (@(posedge clock) disable iff (reset)
    !wait_port.load && wait_port.run && wait_port.tick && s.phase == PHASE_LAST
      && s.count != WAIT_RESET |=> s.count == $past(s.count) - 4'h1)
    else $error("wait counter missed a period step");
endmodule
`default_nettype wire

/* bench/emr_periph_model.sv */
// Memory-mapped converter model on the far side of the read cycle pins
`timescale 1ns/1ps
`default_nettype none
module emr_periph_model
  import emr_pkg::*;
#(
  parameter int CONV_CYCLES = 5
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // Bench control
  input  wire logic                  conv_start,
  input  wire logic [3:0]            slow_cycles,
  // Processor pins
  input  wire logic [ADDR_WIDTH-1:0] external_address,
  input  wire logic                  boot_space_select_n,
  input  wire logic                  data_space_select_n,
  input  wire logic                  program_space_select_n,
  input  wire logic                  io_space_select_n,
  input  wire logic                  read_strobe_n,
  output logic [23:0]                external_data,
  output logic                       conversion_irq_n
);
  logic [3:0]  sel_n;
  logic        chip_sel;
  logic        driving;
  logic        valid;
  logic [23:0] last_value;
  logic [4:0]  low_cycles;
  logic [3:0]  conv_count;
  logic        converting;

  assign sel_n    = {boot_space_select_n, data_space_select_n,
                     program_space_select_n, io_space_select_n};
  assign chip_sel = (sel_n != 4'hF);
  assign driving  = chip_sel && !read_strobe_n;
  assign valid    = driving && (low_cycles >= {1'b0, slow_cycles});
  // Released bus shows the inverse of the last driven word
  assign external_data = valid ? {sel_n, 6'h15, external_address} : ~last_value;

  always_ff @(posedge clock) begin
    if (reset) begin
      low_cycles       <= 5'h00;
      last_value       <= 24'h000000;
      conversion_irq_n <= 1'b1;
      conv_count       <= 4'h0;
      converting       <= 1'b0;
    end else begin
      // Saturates so long strobes never wrap back below the access time
      if (!driving) begin
        low_cycles <= 5'h00;
      end else if (low_cycles != 5'h1F) begin
        low_cycles <= low_cycles + 5'h01;
      end
      if (valid) last_value <= external_data;
      if (conv_start) begin
        converting <= 1'b1;
        conv_count <= 4'h0;
      end else if (converting) begin
        conv_count <= conv_count + 4'h1;
        if (conv_count == 4'(CONV_CYCLES - 1)) begin
          converting       <= 1'b0;
          conversion_irq_n <= 1'b0;
        end
      end
      if (driving) conversion_irq_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the external memory read cycle
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import emr_pkg::*;
;
  typedef struct {
    logic [1:0]  space;
    logic        prog;
    logic [13:0] paddr;
    logic [13:0] daddr;
    logic [3:0]  waits;
    logic [3:0]  slow;
  } emr_row_type;

  logic clock, reset, start_read, use_program_bus, conv_start;
  logic [1:0] read_space;
  logic [ADDR_WIDTH-1:0] program_address, data_address, external_address, hold_addr;
  logic [3:0] boot_wait, program_wait, data_wait, io_wait, slow_cycles, sel_n, hold_sel;
  logic busy, read_done, read_to_program, sample_request, conversion_irq_n, hold_bad;
  logic boot_space_select_n, data_space_select_n, program_space_select_n;
  logic io_space_select_n, read_strobe_n;
  logic [23:0] read_data, external_data;
  int num_errors, n_checks, lo_cnt, sel_cnt, n;
  emr_row_type rows[6];

  emr_read_cycle dut_u (.clock, .reset, .start_read, .read_space, .use_program_bus,
    .program_address, .data_address, .boot_wait, .program_wait, .data_wait, .io_wait,
    .busy, .read_done, .read_to_program, .read_data, .sample_request, .conversion_irq_n,
    .external_data, .external_address, .boot_space_select_n, .data_space_select_n,
    .program_space_select_n, .io_space_select_n, .read_strobe_n);
  emr_periph_model periph_u (.clock, .reset, .conv_start, .slow_cycles, .external_address,
    .boot_space_select_n, .data_space_select_n, .program_space_select_n,
    .io_space_select_n, .read_strobe_n, .external_data, .conversion_irq_n);

  assign sel_n = {boot_space_select_n, data_space_select_n,
                  program_space_select_n, io_space_select_n};

  // Pin monitor: strobe width, setup/hold cycles, stability while low
  always @(posedge clock) begin
    if (read_strobe_n === 1'b0) begin
      if (lo_cnt == 0) begin
        hold_addr = external_address;
        hold_sel = sel_n;
      end else if (external_address !== hold_addr || sel_n !== hold_sel) hold_bad = 1'b1;
      lo_cnt++;
    end else if (sel_n !== 4'hF) sel_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expect_v);
    n_checks++;
    if (seen !== expect_v) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expect_v);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_read(input emr_row_type r);
    logic [ADDR_WIDTH-1:0] a;
    logic [3:0] se;
    a = r.prog ? r.paddr : r.daddr;
    se = 4'hF ^ (4'h8 >> r.space);
    slow_cycles = r.slow;
    lo_cnt = 0;
    sel_cnt = 0;
    hold_bad = 1'b0;
    start_read = 1'b1;
    read_space = r.space;
    use_program_bus = r.prog;
    program_address = r.paddr;
    data_address = r.daddr;
    @(posedge clock);
    #1 start_read = 1'b0;
    n = 0;
    while (read_done !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1 n++;
    end
    check(n, 4 + 4 * r.waits);
    check(lo_cnt, 2 + 4 * r.waits);
    check(read_data, {se, 6'h15, a});
    check(hold_sel, se);
    check(hold_addr, a);
    check(read_to_program, r.prog);
    check(hold_bad, 1'b0);
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    check(sel_cnt, 2);
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Whole run is well under a thousand cycles
  initial begin
    #50000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    num_errors = 0;
    n_checks = 0;
    lo_cnt = 0;
    sel_cnt = 0;
    hold_bad = 1'b0;
    reset = 1'b1;
    start_read = 1'b0;
    conv_start = 1'b0;
    read_space = SPACE_BOOT;
    use_program_bus = 1'b0;
    program_address = 14'h0000;
    data_address = 14'h0000;
    slow_cycles = 4'h0;
    boot_wait = 4'h0;
    data_wait = 4'h5;
    program_wait = 4'h1;
    io_wait = 4'hF;
    rows = '{'{SPACE_BOOT, 1'b0, 14'h0123, 14'h3FFF, 4'h0, 4'h0},
             '{SPACE_DATA, 1'b0, 14'h0123, 14'h2AAA, 4'h5, 4'hF},
             '{SPACE_PROGRAM, 1'b1, 14'h1555, 14'h0000, 4'h1, 4'h0},
             '{SPACE_IO, 1'b0, 14'h3FFF, 14'h0000, 4'hF, 4'hF},
             '{SPACE_IO, 1'b1, 14'h3C3C, 14'h1111, 4'hF, 4'h0},
             '{SPACE_BOOT, 1'b1, 14'h0001, 14'h2222, 4'h0, 4'h0}};
    repeat (4) @(posedge clock);
    #1 reset = 1'b0;
    check({busy, read_done, read_strobe_n, sel_n}, 7'h1F);
    check(read_data, 24'h0);
    check(external_address, 14'h0);
    foreach (rows[i]) do_read(rows[i]);
    // Second request while busy is ignored
    start_read = 1'b1;
    read_space = SPACE_DATA;
    use_program_bus = 1'b0;
    data_address = 14'h0AB0;
    @(posedge clock);
    #1 data_address = 14'h0CD0;
    @(posedge clock);
    #1 start_read = 1'b0;
    n = 0;
    repeat (60) begin
      @(posedge clock);
      #1 if (read_done === 1'b1) n++;
    end
    check(n, 1);
    check(read_data[13:0], 14'h0AB0);
    // Reset in mid-access drops strobe, select and data at once
    start_read = 1'b1;
    read_space = SPACE_IO;
    @(posedge clock);
    #1 start_read = 1'b0;
    repeat (5) @(posedge clock);
    #1 check(read_strobe_n, 1'b0);
    reset = 1'b1;
    repeat (2) @(posedge clock);
    #1 reset = 1'b0;
    check({busy, read_done, read_strobe_n, sel_n}, 7'h1F);
    check(read_data, 24'h0);
    // Conversion finished: request seen three edges after the pin falls
    conv_start = 1'b1;
    @(posedge clock);
    #1 conv_start = 1'b0;
    n = 0;
    while (conversion_irq_n !== 1'b0 && n < 50) begin
      @(posedge clock);
      #1 n++;
    end
    n = 0;
    while (sample_request !== 1'b1 && n < 10) begin
      @(posedge clock);
      #1 n++;
    end
    check(n, 3);
    do_read(rows[4]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
